// >>> core/axpfs_consts.svh
// constants for the axis pin function select block: offsets, fields, codes, reset values
// assumes a 32-bit apb bus with byte addresses and four axes of eight pins each
//
// How it works
// - host loads the 16-bit setting, then command 21h applies it to the pins
// - pin k uses setting bits 2k+1 and 2k
// - code 00 makes an input; levels read back per axis in xy and zu words
// - input pins can trigger synchronous action on a rising or falling edge
// - pins 4 and 5 as inputs can start external-signal relative or continuous driving
// - code 01 drives the pin from output level words xy and zu
// - general output drives low for a stored 0, high for a stored 1
// - code 10 drives the pin's assigned drive status indication
// - code 11: pins 3..0 give sync pulses, pins 7..4 compare results
// - compare outputs follow the compare mode set by command 20h
// - reset clears every setting bit, so all pins start as inputs
`ifndef AXPFS_CONSTS_SVH
`define AXPFS_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define AXPFS_OFS_PARAM_WORD 8'h00
`define AXPFS_OFS_COMMAND 8'h04
`define AXPFS_OFS_OUT_XY 8'h08
`define AXPFS_OFS_OUT_ZU 8'h0C
`define AXPFS_OFS_IN_XY 8'h10
`define AXPFS_OFS_IN_ZU 8'h14
`define AXPFS_OFS_FUNC_XY 8'h18
`define AXPFS_OFS_FUNC_ZU 8'h1C
`define AXPFS_OFS_CMP_MODE 8'h20
`define AXPFS_OFS_EDGE_SEL 8'h24

// ****************************************
// command word fields and codes
// ****************************************
`define AXPFS_CMD_CODE_LSB 0
`define AXPFS_CMD_AXIS_LSB 8
`define AXPFS_CODE_PIN_FUNC 8'h21
`define AXPFS_CODE_CMP_MODE 8'h20

// ****************************************
// pin function field codes
// ****************************************
`define AXPFS_FN_INPUT 2'h0
`define AXPFS_FN_GP_OUT 2'h1
`define AXPFS_FN_STATUS 2'h2
`define AXPFS_FN_SYNC_CMP 2'h3

// ****************************************
// reset values and timing
// ****************************************
`define AXPFS_RST_SETTING 16'h0000
`define AXPFS_RST_WORD 32'h00000000
`define AXPFS_CMD_GAP_NS 125

`endif

// >>> core/axpfs_pkg.sv
// types shared by the axis pin function select block
// assumes the constants header is compiled alongside
package axpfs_pkg;
	typedef logic [15:0] axpfs_setting_t;
	typedef logic [7:0] axpfs_pins_t;
	typedef logic [1:0] axpfs_func_t;
endpackage

// >>> core/axpfs_top.sv
// per-axis function select for eight multi-purpose pins of each of four axes
// every output leaves a flip-flop, so pins follow a setting change one clock later
// edge detectors stay quiet for two clocks after reset while the level stages fill
// assumes apb from a host on pclk; pin levels, drive status, sync pulses and
// compare results arrive synchronous to pclk from the rest of the device
`include "axpfs_consts.svh"

module axpfs_top #(
	parameter int AXES = 4,
	parameter int PINS = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [AXES*PINS-1:0] axis_multi_pins_in,
	output logic [AXES*PINS-1:0] axis_multi_pins_out,
	output logic [AXES*PINS-1:0] axis_multi_pins_oe,
	input wire logic [AXES*PINS-1:0] drive_status,
	input wire logic [AXES*4-1:0] sync_pulse,
	input wire logic [AXES*4-1:0] compare_result,
	output logic [AXES*16-1:0] compare_mode,
	output logic [AXES*PINS-1:0] sync_trigger,
	output logic [AXES-1:0] ext_start_relative,
	output logic [AXES-1:0] ext_start_continuous
);

	// ****************************************
	// register state
	// ****************************************
	axpfs_pkg::axpfs_setting_t param_word_reg;
	axpfs_pkg::axpfs_setting_t pin_func_reg [AXES];
	axpfs_pkg::axpfs_setting_t cmp_mode_reg [AXES];
	logic [31:0] out_xy_reg;
	logic [31:0] out_zu_reg;
	logic [31:0] edge_sel_reg;
	logic [AXES*PINS-1:0] level_reg;
	logic [AXES*PINS-1:0] level_prev_reg;
	logic [31:0] rdata_next;
	logic addr_ok;
	logic setup;
	logic access_done;
	logic [AXES*PINS-1:0] gp_out_bits;
	// write strobes and command fields
	logic wr_param;
	logic wr_command;
	logic wr_out_xy;
	logic wr_out_zu;
	logic wr_edge_sel;
	logic [7:0] cmd_code;
	logic [AXES-1:0] cmd_axes;
	// edge detector warm-up
	logic [1:0] prime_reg;
	logic edges_ok;

	assign setup = psel & ~penable;
	// a write lands only at the edge where the access completes
	assign access_done = psel & penable & pready;

	// ****************************************
	// apb write decode
	// ****************************************
	// one strobe per writable word, so each register has its own process
	assign wr_param = access_done & pwrite & (paddr == `AXPFS_OFS_PARAM_WORD);
	assign wr_command = access_done & pwrite & (paddr == `AXPFS_OFS_COMMAND);
	assign wr_out_xy = access_done & pwrite & (paddr == `AXPFS_OFS_OUT_XY);
	assign wr_out_zu = access_done & pwrite & (paddr == `AXPFS_OFS_OUT_ZU);
	assign wr_edge_sel = access_done & pwrite & (paddr == `AXPFS_OFS_EDGE_SEL);

	// command word: code in the low byte, one select bit per axis above it
	assign cmd_code = pwdata[`AXPFS_CMD_CODE_LSB +: 8];
	assign cmd_axes = pwdata[`AXPFS_CMD_AXIS_LSB +: AXES];

	// general output bits in pin order: x and y from the xy word, z and u from zu
	assign gp_out_bits = {out_zu_reg[15:0], out_xy_reg[15:0]};

	// ****************************************
	// apb read decode
	// ****************************************
	always_comb begin
		rdata_next = `AXPFS_RST_WORD;
		addr_ok = 1'b1;
		unique case (paddr)
			`AXPFS_OFS_PARAM_WORD: rdata_next = {16'h0000, param_word_reg};
			`AXPFS_OFS_COMMAND: rdata_next = `AXPFS_RST_WORD;
			`AXPFS_OFS_OUT_XY: rdata_next = out_xy_reg;
			`AXPFS_OFS_OUT_ZU: rdata_next = out_zu_reg;
			`AXPFS_OFS_IN_XY: rdata_next = {16'h0000, level_reg[15:0]};
			`AXPFS_OFS_IN_ZU: rdata_next = {16'h0000, level_reg[31:16]};
			`AXPFS_OFS_FUNC_XY: rdata_next = {pin_func_reg[1], pin_func_reg[0]};
			`AXPFS_OFS_FUNC_ZU: rdata_next = {pin_func_reg[3], pin_func_reg[2]};
			`AXPFS_OFS_CMP_MODE: rdata_next = {cmp_mode_reg[1], cmp_mode_reg[0]};
			`AXPFS_OFS_EDGE_SEL: rdata_next = edge_sel_reg;
			default: addr_ok = 1'b0;
		endcase
	end

	// ****************************************
	// apb handshake: answer in the first access cycle
	// ****************************************
	// ready in the first access cycle only, so every transfer has zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	// error answer for unmapped offsets, raised together with ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup & ~addr_ok;
		end
	end

	// ****************************************
	// apb read data
	// ****************************************
	// captured at setup; it stays put until the next read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `AXPFS_RST_WORD;
		end else if (setup && !pwrite) begin
			prdata <= rdata_next;
		end
	end

	// ****************************************
	// host writable words
	// ****************************************
	// staging word for the next command; nothing changes on the pins yet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			param_word_reg <= `AXPFS_RST_SETTING;
		end else if (wr_param) begin
			param_word_reg <= pwdata[15:0];
		end
	end

	// output levels for x and y; the upper half is kept clear and reads zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_xy_reg <= `AXPFS_RST_WORD;
		end else if (wr_out_xy) begin
			out_xy_reg <= {16'h0000, pwdata[15:0]};
		end
	end

	// output levels for z and u
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_zu_reg <= `AXPFS_RST_WORD;
		end else if (wr_out_zu) begin
			out_zu_reg <= {16'h0000, pwdata[15:0]};
		end
	end

	// edge choice per pin for synchronous action triggers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_sel_reg <= `AXPFS_RST_WORD;
		end else if (wr_edge_sel) begin
			edge_sel_reg <= pwdata;
		end
	end

	// ****************************************
	// per-axis settings, commands and pin drivers
	// ****************************************
	genvar a;
	genvar k;
	generate
		for (a = 0; a < AXES; a++) begin : g_axis
			logic cmd_hit;
			// the axis takes a command only when its select bit is set
			assign cmd_hit = wr_command & cmd_axes[a];

			// ****************************************
			// per-axis settings
			// ****************************************
			// settings of unselected axes are left untouched
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_func_reg[a] <= `AXPFS_RST_SETTING;
				end else if (cmd_hit && cmd_code == `AXPFS_CODE_PIN_FUNC) begin
					pin_func_reg[a] <= param_word_reg;
				end
			end

			// compare mode is staged the same way; unknown codes change nothing
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cmp_mode_reg[a] <= `AXPFS_RST_SETTING;
				end else if (cmd_hit && cmd_code == `AXPFS_CODE_CMP_MODE) begin
					cmp_mode_reg[a] <= param_word_reg;
				end
			end

			// ****************************************
			// compare mode output
			// ****************************************
			// comparators elsewhere read their object and condition from here
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					compare_mode[a*16 +: 16] <= `AXPFS_RST_SETTING;
				end else begin
					compare_mode[a*16 +: 16] <= cmp_mode_reg[a];
				end
			end

			// ****************************************
			// external drive starts
			// ****************************************
			// relative driving starts on the active-low falling edge of pin 4
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ext_start_relative[a] <= 1'b0;
				end else begin
					ext_start_relative[a] <= edges_ok
						& (pin_func_reg[a][9:8] == `AXPFS_FN_INPUT)
						& level_prev_reg[a*PINS+4] & ~level_reg[a*PINS+4];
				end
			end

			// continuous driving starts on the falling edge of pin 5
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ext_start_continuous[a] <= 1'b0;
				end else begin
					ext_start_continuous[a] <= edges_ok
						& (pin_func_reg[a][11:10] == `AXPFS_FN_INPUT)
						& level_prev_reg[a*PINS+5] & ~level_reg[a*PINS+5];
				end
			end

			for (k = 0; k < PINS; k++) begin : g_pin
				localparam int P = a*PINS + k;
				axpfs_pkg::axpfs_func_t fn;
				logic drive_val;
				logic gp_bit;
				assign fn = pin_func_reg[a][2*k +: 2];
				assign gp_bit = gp_out_bits[P];

				// ****************************************
				// per-pin function multiplexer
				// ****************************************
				// select the level this pin presents in its output modes
				always_comb begin
					drive_val = 1'b0;
					unique case (fn)
						`AXPFS_FN_INPUT: drive_val = 1'b0;
						`AXPFS_FN_GP_OUT: drive_val = gp_bit;
						`AXPFS_FN_STATUS: drive_val = drive_status[P];
						`AXPFS_FN_SYNC_CMP: begin
							// low half sync pulses, high half compare results
							if (k < 4) begin
								drive_val = sync_pulse[a*4 + (k%4)];
							end else begin
								drive_val = compare_result[a*4 + (k%4)];
							end
						end
					endcase
				end

				// ****************************************
				// pin drivers
				// ****************************************
				// registered drivers keep the pins glitch free across mode changes
				always_ff @(posedge pclk or negedge presetn) begin
					if (!presetn) begin
						axis_multi_pins_out[P] <= 1'b0;
					end else begin
						axis_multi_pins_out[P] <= drive_val;
					end
				end

				// enable follows the mode; input pins are released, never driven low
				always_ff @(posedge pclk or negedge presetn) begin
					if (!presetn) begin
						axis_multi_pins_oe[P] <= 1'b0;
					end else begin
						axis_multi_pins_oe[P] <= (fn != `AXPFS_FN_INPUT);
					end
				end

				// ****************************************
				// synchronous action triggers
				// ****************************************
				// edge_sel bit set picks the rising edge, clear the falling edge
				always_ff @(posedge pclk or negedge presetn) begin
					if (!presetn) begin
						sync_trigger[P] <= 1'b0;
					end else if (fn != `AXPFS_FN_INPUT || !edges_ok) begin
						sync_trigger[P] <= 1'b0;
					end else if (edge_sel_reg[P]) begin
						sync_trigger[P] <= ~level_prev_reg[P] & level_reg[P];
					end else begin
						sync_trigger[P] <= level_prev_reg[P] & ~level_reg[P];
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// pin level capture
	// ****************************************
	// pins are taken as synchronous, so one stage suffices for readback
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_reg <= '0;
		end else begin
			level_reg <= axis_multi_pins_in;
		end
	end

	// previous level for the edge detectors
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_prev_reg <= '0;
		end else begin
			level_prev_reg <= level_reg;
		end
	end

	// ****************************************
	// edge detector warm-up
	// ****************************************
	// both level stages hold reset zeros at first; a pin that idles high
	// would otherwise look like a rising edge right after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prime_reg <= 2'h0;
		end else begin
			prime_reg <= {prime_reg[0], 1'b1};
		end
	end

	assign edges_ok = prime_reg[1];

endmodule // axpfs_top

// >>> verif/axpfs_properties.sv
// checker for the pin function select block, bound to its top module
// assumes zero-wait apb and the 21h command with the axis mask in bits 11:8
module axpfs_properties #(
	parameter int AXES = 4,
	parameter int PINS = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [AXES*PINS-1:0] axis_multi_pins_in,
	input wire logic [AXES*PINS-1:0] axis_multi_pins_out,
	input wire logic [AXES*PINS-1:0] axis_multi_pins_oe,
	input wire logic [AXES*PINS-1:0] drive_status,
	input wire logic [AXES*4-1:0] sync_pulse,
	input wire logic [AXES*4-1:0] compare_result,
	input wire logic [AXES-1:0] ext_start_relative
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] pw_reg;
	logic [63:0] fn_reg;
	logic [31:0] lv_reg, m_in, m_gp, m_st, m_sc, want;
	wire wr = psel && penable && pready && pwrite;
	// shadow of software writes, so outputs can be tied to their cause
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pw_reg <= 16'h0000;
			fn_reg <= 64'h0;
			lv_reg <= 32'h0;
		end else if (wr) begin
			if (paddr == 8'h00) pw_reg <= pwdata[15:0];
			if (paddr == 8'h08) lv_reg[15:0] <= pwdata[15:0];
			if (paddr == 8'h0C) lv_reg[31:16] <= pwdata[15:0];
			for (int a = 0; a < 4; a++)
				if (paddr == 8'h04 && pwdata[7:0] == 8'h21 && pwdata[8+a]) fn_reg[a*16+:16] <= pw_reg;
		end
	end
	// per-pin mode decode; sync and compare sources share one index
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			m_in[i] = fn_reg[i*2+:2] == 2'h0;
			m_gp[i] = fn_reg[i*2+:2] == 2'h1;
			m_st[i] = fn_reg[i*2+:2] == 2'h2;
			m_sc[i] = fn_reg[i*2+:2] == 2'h3;
			want[i] = (i % 8 < 4) ? sync_pulse[i/8*4+i%4] : compare_result[i/8*4+i%4];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup; psel && !penable; endsequence
	sequence s_done; psel && penable && pready; endsequence
	sequence s_fall4; $fell(axis_multi_pins_in[4]) && m_in[4] ##1 m_in[4]; endsequence
	AST_ZERO_WAIT: assert property (s_setup |=> s_done)
		else $error("apb access not answered at once");
	AST_RESET_INPUTS: assert property ($rose(presetn) |-> axis_multi_pins_oe == 32'h0)
		else $error("pin driven right after reset");
	AST_INPUT_RELEASED: assert property (axis_multi_pins_oe == ~$past(m_in))
		else $error("pin enable does not follow mode");
	AST_INPUT_LOW: assert property ((axis_multi_pins_out & $past(m_in)) == 32'h0)
		else $error("input pin shows a level");
	AST_GP_LEVEL: assert property (((axis_multi_pins_out ^ $past(lv_reg)) & $past(m_gp)) == 32'h0)
		else $error("general output level wrong");
	AST_STATUS_PASS: assert property (((axis_multi_pins_out ^ $past(drive_status)) & $past(m_st)) == 32'h0)
		else $error("drive status not on pin");
	AST_SYNC_CMP: assert property (((axis_multi_pins_out ^ $past(want)) & $past(m_sc)) == 32'h0)
		else $error("sync or compare output wrong");
	AST_EXT_RELATIVE: assert property (s_fall4 |-> ##[0:2] ext_start_relative[0])
		else $error("no relative start on pin four fall");
endmodule // axpfs_properties

bind axpfs_top axpfs_properties #(.AXES(AXES), .PINS(PINS)) chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .axis_multi_pins_in(axis_multi_pins_in),
	.axis_multi_pins_out(axis_multi_pins_out), .axis_multi_pins_oe(axis_multi_pins_oe),
	.drive_status(drive_status), .sync_pulse(sync_pulse), .compare_result(compare_result),
	.ext_start_relative(ext_start_relative));

// >>> verif/axpfs_machine_model.sv
// machine side of the pins: resolves each wire from both drivers
// assumes the bench supplies the machine's own levels
module axpfs_machine_model (
	input wire logic [31:0] ext_level,
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe,
	output logic [31:0] pin_wire
);
	timeunit 1ns;
	timeprecision 1ps;
	// released pins show the machine, driven ones the device
	assign pin_wire = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // axpfs_machine_model

// >>> verif/axis_pin_function_select_tb.sv
// self-checking bench for the pin function select block
// assumes zero-wait apb and a machine model on the pins
module axis_pin_function_select_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, lvl, ext, pw, po, poe, ds, trig;
	logic [15:0] sp, cr, sv;
	logic [63:0] set, cm;
	logic [3:0] rel, cont;
	int n_errors, check_count, nt, nr, nc;
	axpfs_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .axis_multi_pins_in(pw), .axis_multi_pins_out(po),
		.axis_multi_pins_oe(poe), .drive_status(ds), .sync_pulse(sp), .compare_result(cr),
		.compare_mode(cm), .sync_trigger(trig), .ext_start_relative(rel),
		.ext_start_continuous(cont));
	axpfs_machine_model mdl (.ext_level(ext), .pin_out(po), .pin_oe(poe), .pin_wire(pw));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic stop_test();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is seen; starts a clock after the last
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// host leaves five clocks after a command word before the next write
		if (w && a == 8'h04)
			repeat (5) @(posedge pclk);
	endtask
	// expected pin levels for a full set of four axis settings
	function automatic logic [31:0] exp_out(input logic [63:0] s);
		logic [31:0] e;
		for (int i = 0; i < 32; i++)
			case (s[2*i+:2])
				2'h1: e[i] = lvl[i];
				2'h2: e[i] = ds[i];
				2'h3: e[i] = (i % 8 < 4) ? sp[i/8*4+i%4] : cr[i/8*4+i%4];
				default: e[i] = 1'b0;
			endcase
		return e;
	endfunction
	function automatic logic [31:0] exp_oe(input logic [63:0] s);
		for (int i = 0; i < 32; i++)
			exp_oe[i] = s[2*i+:2] != 2'h0;
	endfunction
	initial begin
		#100us;
		n_errors++;
		stop_test();
	end
	// main sequence: reset, modes per axis, readback, edge starts
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{ext, ds, sp, cr, set} = '0;
		void'($urandom(32'h4DAE));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(poe, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		check(rd, 32'h0);
		for (int t = 0; t < 6; t++) begin
			for (int a = 0; a < 4; a++) begin
				sv = (t == 0) ? 16'hE4E4 : (t == 1) ? 16'h1B1B : 16'($urandom);
				apb(1'b1, 8'h00, {16'h0, sv});
				apb(1'b1, 8'h04, 32'h21 | (32'h100 << a));
				set[a*16+:16] = sv;
			end
			lvl = $urandom;
			ds <= $urandom;
			sp <= 16'($urandom);
			cr <= 16'($urandom);
			ext <= $urandom;
			apb(1'b1, 8'h08, {16'h0, lvl[15:0]});
			apb(1'b1, 8'h0C, {16'h0, lvl[31:16]});
			repeat (3) @(posedge pclk);
			check(poe, exp_oe(set));
			check(po, exp_out(set));
			apb(1'b0, 8'h18, 32'h0);
			check(rd, set[31:0]);
			apb(1'b0, 8'h1C, 32'h0);
			check(rd, set[63:32]);
		end
		apb(1'b1, 8'h04, 32'hF22);
		apb(1'b0, 8'h18, 32'h0);
		check(rd, set[31:0]);
		sv = 16'($urandom);
		apb(1'b1, 8'h00, {16'h0, sv});
		apb(1'b1, 8'h04, 32'h320);
		apb(1'b0, 8'h20, 32'h0);
		check(rd, {sv, sv});
		check(cm[31:0], {sv, sv});
		check(cm[63:32], 32'h0);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h04, 32'hF21);
		ext <= $urandom;
		repeat (3) @(posedge pclk);
		apb(1'b0, 8'h10, 32'h0);
		check(rd, {16'h0, ext[15:0]});
		apb(1'b0, 8'h14, 32'h0);
		check(rd, {16'h0, ext[31:16]});
		for (int e = 0; e < 2; e++) begin
			apb(1'b1, 8'h24, 32'(e) << 4);
			ext[5:4] <= {2{e == 0}};
			repeat (4) @(posedge pclk);
			ext[5:4] <= {2{e == 1}};
			{nt, nr, nc} = '0;
			repeat (6) begin
				@(posedge pclk);
				nt += trig[4];
				nr += rel[0];
				nc += cont[0];
			end
			check(32'(nt), 32'h1);
			check(32'(nr), 32'(e == 0));
			check(32'(nc), 32'(e == 0));
		end
		apb(1'b0, 8'h40, 32'h0);
		check({31'h0, er}, 32'h1);
		stop_test();
	end
endmodule // axis_pin_function_select_tb
